// File: ata_host_reader.sv
// Host-side reader model that takes identify words with optional stalls
`timescale 1ns/1ns
module ata_host_reader
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Word stream
	input wire logic word_valid_i,
	output logic word_ready_o,
	// Pacing
	input wire logic slow_i
);
	// Ready is a level; a slow host stalls most cycles so the queue backs up
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			word_ready_o <= 1'b0;
		else if (slow_i && word_valid_i)
			word_ready_o <= ($urandom_range(3) == 0);
		else
			word_ready_o <= 1'b1;
	end
endmodule // ata_host_reader

// File: ata_id_fifo.sv
// Small synchronous FIFO between word generator and host read port
`timescale 1ns/1ns
module ata_id_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic do_wr;
	logic do_rd;

	// Honest flags straight from the occupancy count
	assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign do_wr = in_valid_i && in_ready_o;
	assign do_rd = out_valid_o && out_ready_i;
	assign out_data_o = mem_reg[rd_ptr_reg];

	// Storage has no reset; only pointers and count need a known value
	always_ff @(posedge clk_i)
	begin
		if (do_wr)
			mem_reg[wr_ptr_reg] <= in_data_i;
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (do_rd)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			if (do_wr && !do_rd)
				count_reg <= count_reg + 1'b1;
			else if (do_rd && !do_wr)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule // ata_id_fifo

// File: ata_id_map.svh
// Word indices, fixed word values and counts for the identify parameter block
// Function
// - Opcode 11101100 starts the block; 256 words return, those past 128 zero.
// - Word 0 reads bit 6 set, every other bit clear.
// - Default geometry 3FFF cylinders, 16 heads; words 60-61 carry LBA capacity.
// - Words 10-19 carry a 20-character right-justified serial number.
// - Words 23-26 carry an 8-character left-justified firmware revision.
// - Words 27-46 carry a 40-character left-justified model, blanks filling gaps.
// - Word 49 sets bits 11, 9, 8 and clears bits 13 and 10.
// - Word 51 upper byte is 04, meaning PIO mode 4.
// - Word 53 sets bits 2, 1, 0; bits 15 to 3 zero.
// - Word 59 bit 8 marks multiple enabled; low byte gives its sector count.
// - Word 63 bits 10-8 show selected DMA mode, bits 2-0 support.
// - Word 64 sets bits 1 and 0; upper byte zero.
// - Word 80 sets bits 5 through 1; all others zero.
// - Word 82 sets 13,12,10,6,5,3,1,0 and clears the remaining support bits.
// - Word 83 bit 14 one, bit 3 one, all others zero.
// - Word 85 mirrors enabled features on supported bits; other bits zero.
`ifndef ATA_ID_MAP_SVH
`define ATA_ID_MAP_SVH

`define CMD_IDENTIFY 8'hec
`define BLOCK_LAST 8'hff
`define LAST_NONZERO 8'h80

`define W_GENCFG 8'h00
`define W_CYLS 8'h01
`define W_HEADS 8'h03
`define W_SPT 8'h06
`define W_SERIAL_FIRST 8'h0a
`define W_SERIAL_LAST 8'h13
`define W_OLDSPEC 8'h14
`define W_BUFSIZE 8'h15
`define W_ECCBYTES 8'h16
`define W_FWREV_FIRST 8'h17
`define W_MODEL_LAST 8'h2e
`define W_MAXMULT 8'h2f
`define W_CAPS 8'h31
`define W_CAPS2 8'h32
`define W_PIO 8'h33
`define W_SWDMA 8'h34
`define W_VALID 8'h35
`define W_CUR_CYLS 8'h36
`define W_CUR_HEADS 8'h37
`define W_CUR_SPT 8'h38
`define W_CUR_CAP_LO 8'h39
`define W_CUR_CAP_HI 8'h3a
`define W_MULT 8'h3b
`define W_LBA_LO 8'h3c
`define W_LBA_HI 8'h3d
`define W_MWDMA 8'h3f
`define W_ADV_PIO 8'h40
`define W_MWDMA_MIN 8'h41
`define W_MWDMA_REC 8'h42
`define W_PIO_MIN 8'h43
`define W_PIO_IORDY 8'h44
`define W_MAJOR 8'h50
`define W_MINOR 8'h51
`define W_SUPPORT 8'h52
`define W_SUPPORT2 8'h53
`define W_SUPPORT_EXT 8'h54
`define W_ENABLED 8'h55
`define W_DEFAULT 8'h57

// Offset from block index into the packed text table (serial starts at 0)
`define TXT_SERIAL_BASE 8'h0a
`define TXT_FWREV_BASE 8'h0d
`define BLANK 8'h20

`define V_GENCFG 16'h0040
`define V_CYLS 16'h3fff
`define V_HEADS 16'h0010
`define V_SPT 16'h003f
`define V_OLDSPEC 16'h0003
`define V_BUFSIZE 16'h0400
`define V_ECCBYTES 16'h0004
`define V_MAXMULT 16'h8010
`define V_CAPS 16'h0b00
`define V_CAPS2 16'h4000
`define V_PIO 16'h0400
`define V_SWDMA 16'h0200
`define V_VALID 16'h0007
`define V_MWDMA_SUP 3'h7
`define V_ADV_PIO 16'h0003
`define V_CYCLE_120 16'h0078
`define V_CYCLE_240 16'h00f0
`define V_MAJOR 16'h003e
`define V_MINOR 16'h0015
`define V_SUPPORT 16'h346b
`define V_SUPPORT2 16'h4008
`define V_EXT 16'h4000
`define V_LBA_CAP 32'h0100_0000

`endif

// File: ata_id_pkg.sv
// Types shared by the identify block builder
package ata_id_pkg;

	// Live drive configuration, sampled when a command is taken
	typedef struct packed {
		logic [15:0] cur_cyl;
		logic [15:0] cur_heads;
		logic [15:0] cur_spt;
		logic [31:0] cur_cap;
		logic mult_en;
		logic [7:0] mult_count;
		logic [2:0] dma_sel;
		logic [15:0] feat_en;
	} cfg_t;

	// Word generator sequence
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_PUSH = 2'b10
	} state_t;

endpackage

// File: ata_id_text_rom.sv
// Text fields of the identify block: serial, firmware revision, model
`timescale 1ns/1ns
`include "ata_id_map.svh"
module ata_id_text_rom #(
	parameter logic [159:0] SERIAL = "SN0000000001",
	parameter logic [63:0] FWREV = "1.00    ",
	parameter logic [319:0] MODEL = "GENERIC ATA DISK                        "
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Lookup
	input wire logic [7:0] index_i,
	output logic [15:0] text_word_o,
	output logic text_hit_o
);
	localparam int NWORDS = 34;
	localparam logic [NWORDS*16-1:0] TEXT = {SERIAL, FWREV, MODEL};

	logic [15:0] table_w [NWORDS];
	logic [7:0] slot;
	logic hit;

	// Zero bytes become blanks; short serials pad on the left, so stay right-justified
	for (genvar w = 0; w < NWORDS; w++)
	begin : g_word
		for (genvar b = 0; b < 2; b++)
		begin : g_byte
			localparam logic [7:0] CH = TEXT[NWORDS*16-1-16*w-8*(1-b) -: 8];
			assign table_w[w][8*b +: 8] = (CH == 8'h00) ? `BLANK : CH;
		end
	end

	// Serial first, then firmware and model share one contiguous run
	always_comb
	begin
		hit = 1'b0;
		slot = 8'h00;
		if (index_i >= `W_SERIAL_FIRST && index_i <= `W_SERIAL_LAST)
		begin
			hit = 1'b1;
			slot = index_i - `TXT_SERIAL_BASE;
		end
		else if (index_i >= `W_FWREV_FIRST && index_i <= `W_MODEL_LAST)
		begin
			hit = 1'b1;
			slot = index_i - `TXT_FWREV_BASE;
		end
	end

	// Registered read
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			text_word_o <= 16'h0000;
			text_hit_o <= 1'b0;
		end
		else
		begin
			text_word_o <= hit ? table_w[slot[5:0]] : 16'h0000;
			text_hit_o <= hit;
		end
	end

	a_text_no_nul: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		text_hit_o |-> (text_word_o[15:8] != 8'h00 && text_word_o[7:0] != 8'h00))
		else $error("text word holds a NUL byte");

endmodule // ata_id_text_rom

// File: ata_identify_data_builder.sv
// Identify parameter block generator: command decode, word build, output FIFO
`timescale 1ns/1ns
`include "ata_id_map.svh"
module ata_identify_data_builder
	import ata_id_pkg::*;
#(
	parameter logic [31:0] LBA_CAPACITY = `V_LBA_CAP,
	parameter logic [159:0] SERIAL = "SN0000000001",
	parameter logic [63:0] FWREV = "1.00    ",
	parameter logic [319:0] MODEL = "GENERIC ATA DISK                        ",
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Command strobe from the task-file decoder
	input wire logic cmd_valid_i,
	input wire logic [7:0] cmd_code_i,
	// Live configuration
	input wire cfg_t cfg_i,
	// Word stream toward the data register
	output logic [15:0] word_o,
	output logic word_valid_o,
	input wire logic word_ready_i,
	// Status
	output logic busy_o,
	output logic done_o
);

	logic rst_meta_reg;
	logic rst_n_reg;
	state_t state_reg;
	logic [7:0] index_reg;
	cfg_t snap_reg;
	logic [15:0] fixed_reg;
	logic [15:0] fixed_next;
	logic [15:0] text_word;
	logic text_hit;
	logic [15:0] push_data;
	logic push_valid;
	logic push_ready;
	logic cmd_take;
	logic done_reg;
	logic [8:0] queued_cnt_reg;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// Only the identify opcode starts a block; anything else is left to other units
	assign cmd_take = cmd_valid_i && (cmd_code_i == `CMD_IDENTIFY) && (state_reg == ST_IDLE);

	// Sequencer: fetch one word, then hold it until the FIFO takes it
	always_ff @(posedge ref_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			state_reg <= ST_IDLE;
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (cmd_take)
						state_reg <= ST_FETCH;
				ST_FETCH:
					state_reg <= ST_PUSH;
				ST_PUSH:
					if (push_ready)
						state_reg <= (index_reg == `BLOCK_LAST) ? ST_IDLE : ST_FETCH;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Word index walks 0 to 255 once per command
	always_ff @(posedge ref_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			index_reg <= 8'h00;
		else if (cmd_take)
			index_reg <= 8'h00;
		else if (state_reg == ST_PUSH && push_ready)
			index_reg <= index_reg + 8'h01;
	end

	// Snapshot keeps the block self-consistent if config moves mid-transfer
	always_ff @(posedge ref_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			snap_reg <= '0;
		else if (cmd_take)
			snap_reg <= cfg_i;
	end

	// One-cycle pulse once the last word is queued
	always_ff @(posedge ref_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			done_reg <= 1'b0;
		else
			done_reg <= (state_reg == ST_PUSH) && push_ready && (index_reg == `BLOCK_LAST);
	end

	// Words queued for the current command
	// Only feeds a length check; restarts on every accepted command
	always_ff @(posedge ref_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			queued_cnt_reg <= 9'h000;
		else if (cmd_take)
			queued_cnt_reg <= 9'h000;
		else if (push_valid && push_ready)
			queued_cnt_reg <= queued_cnt_reg + 9'h001;
	end

	// Non-text words; text positions fall to zero here and come from the ROM
	always_comb
	begin
		fixed_next = 16'h0000;
		case (index_reg)
			`W_GENCFG: fixed_next = `V_GENCFG;
			`W_CYLS: fixed_next = `V_CYLS;
			`W_HEADS: fixed_next = `V_HEADS;
			`W_SPT: fixed_next = `V_SPT;
			`W_OLDSPEC: fixed_next = `V_OLDSPEC;
			`W_BUFSIZE: fixed_next = `V_BUFSIZE;
			`W_ECCBYTES: fixed_next = `V_ECCBYTES;
			`W_MAXMULT: fixed_next = `V_MAXMULT;
			`W_CAPS: fixed_next = `V_CAPS;
			`W_CAPS2: fixed_next = `V_CAPS2;
			`W_PIO: fixed_next = `V_PIO;
			`W_SWDMA: fixed_next = `V_SWDMA;
			`W_VALID: fixed_next = `V_VALID;
			`W_CUR_CYLS: fixed_next = snap_reg.cur_cyl;
			`W_CUR_HEADS: fixed_next = snap_reg.cur_heads;
			`W_CUR_SPT: fixed_next = snap_reg.cur_spt;
			`W_CUR_CAP_LO: fixed_next = snap_reg.cur_cap[15:0];
			`W_CUR_CAP_HI: fixed_next = snap_reg.cur_cap[31:16];
			`W_MULT: fixed_next = {7'h00, snap_reg.mult_en, snap_reg.mult_count};
			`W_LBA_LO: fixed_next = LBA_CAPACITY[15:0];
			`W_LBA_HI: fixed_next = LBA_CAPACITY[31:16];
			`W_MWDMA: fixed_next = {5'h00, snap_reg.dma_sel, 5'h00, `V_MWDMA_SUP};
			`W_ADV_PIO: fixed_next = `V_ADV_PIO;
			`W_MWDMA_MIN: fixed_next = `V_CYCLE_120;
			`W_MWDMA_REC: fixed_next = `V_CYCLE_120;
			`W_PIO_MIN: fixed_next = `V_CYCLE_240;
			`W_PIO_IORDY: fixed_next = `V_CYCLE_120;
			`W_MAJOR: fixed_next = `V_MAJOR;
			`W_MINOR: fixed_next = `V_MINOR;
			`W_SUPPORT: fixed_next = `V_SUPPORT;
			`W_SUPPORT2: fixed_next = `V_SUPPORT2;
			`W_SUPPORT_EXT: fixed_next = `V_EXT;
			`W_ENABLED: fixed_next = snap_reg.feat_en & `V_SUPPORT;
			`W_DEFAULT: fixed_next = `V_EXT;
			default: fixed_next = 16'h0000;
		endcase
	end

	// Registered alongside the ROM so both land in the push cycle
	always_ff @(posedge ref_clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			fixed_reg <= 16'h0000;
		else if (state_reg == ST_FETCH)
			fixed_reg <= fixed_next;
	end

	// Text fields
	ata_id_text_rom #(
		.SERIAL(SERIAL),
		.FWREV(FWREV),
		.MODEL(MODEL)
	) u_text (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_reg),
		.index_i(index_reg),
		.text_word_o(text_word),
		.text_hit_o(text_hit)
	);

	// ROM holds its word while the index is steady, so back-pressure is safe
	assign push_valid = (state_reg == ST_PUSH);
	assign push_data = text_hit ? text_word : fixed_reg;

	// Output buffer; a stalled host stalls the sequencer
	ata_id_fifo #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_reg),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(push_data),
		.out_valid_o(word_valid_o),
		.out_ready_i(word_ready_i),
		.out_data_o(word_o)
	);

	// Busy until the last word is queued, not drained
	assign busy_o = (state_reg != ST_IDLE);
	assign done_o = done_reg;

	a_opcode_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(cmd_take) |=> (state_reg == ST_FETCH && index_reg == 8'h00))
		else $error("identify opcode did not start the block at word 0");

	a_other_opcode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(state_reg == ST_IDLE && !(cmd_valid_i && cmd_code_i == `CMD_IDENTIFY)) |=> (state_reg == ST_IDLE))
		else $error("block started without the identify opcode");

	a_high_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg > `LAST_NONZERO) |-> (push_data == 16'h0000))
		else $error("word beyond 128 is not zero");

	a_gencfg_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_GENCFG) |-> (push_data == 16'h0040))
		else $error("general configuration word wrong");

	a_geometry_words: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_HEADS && $past(state_reg) == ST_FETCH)
			|-> (push_data == 16'h0010 && $past(index_reg, 3) == 8'h02))
		else $error("heads word wrong or out of order");

	a_lba_words: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && push_ready && index_reg == `W_LBA_LO) |=> ##1 (push_valid
			&& index_reg == `W_LBA_HI && push_data == LBA_CAPACITY[31:16]))
		else $error("LBA capacity high word wrong");

	a_caps_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_CAPS) |-> (push_data[13:8] == 6'h0b))
		else $error("capabilities bits wrong");

	a_pio_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_PIO) |-> (push_data[15:8] == 8'h04))
		else $error("PIO mode byte wrong");

	a_valid_flags: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_VALID) |-> (push_data == 16'h0007))
		else $error("field validity word wrong");

	a_mult_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_MULT)
			|-> (push_data == {7'h00, snap_reg.mult_en, snap_reg.mult_count}))
		else $error("multiple count word wrong");

	a_dma_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_MWDMA) |-> (push_data[10:8] == snap_reg.dma_sel
			&& push_data[2:0] == 3'h7 && push_data[15:11] == 5'h00))
		else $error("multiword DMA word wrong");

	a_adv_pio: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_ADV_PIO) |-> (push_data == 16'h0003))
		else $error("advanced PIO word wrong");

	a_major_version: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_MAJOR) |-> (push_data == 16'h003e))
		else $error("major version word wrong");

	a_support_sets: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_SUPPORT) |-> (push_data == 16'h346b))
		else $error("command set support word wrong");

	a_support_ext: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_SUPPORT2) |-> (push_data == 16'h4008))
		else $error("second support word wrong");

	a_enabled_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_ENABLED)
			|-> ((push_data & 16'hcb94) == 16'h0000 && push_data == (snap_reg.feat_en & 16'h346b)))
		else $error("enabled features word wrong");

	a_snapshot_live: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(cmd_take) |=> (snap_reg == $past(cfg_i)) ##1 (snap_reg == $past(cfg_i, 2)))
		else $error("configuration not sampled at command");

	a_snapshot_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(state_reg != ST_IDLE) |=> $stable(snap_reg))
		else $error("configuration snapshot moved during a block");

	a_cap_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_CUR_CAP_HI) |-> (push_data == snap_reg.cur_cap[31:16]))
		else $error("current capacity high word wrong");

	// Sequencing: start, step, stall, length and end of one block
	a_first_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(cmd_take) |=> ##1 (push_valid && index_reg == 8'h00 && push_data == 16'h0040))
		else $error("first word not offered two cycles after the command");

	a_busy_refuse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(cmd_valid_i && state_reg != ST_IDLE) |=> (state_reg != ST_FETCH || index_reg != 8'h00))
		else $error("command restarted a block in progress");

	// A stalled push keeps its index, so the step is checked on the handshake only
	a_index_step: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && push_ready && index_reg != `BLOCK_LAST)
			|=> (state_reg == ST_FETCH && index_reg == $past(index_reg) + 8'h01))
		else $error("word index did not advance by one");

	a_push_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && !push_ready) |=> (push_valid && $stable(index_reg) && $stable(push_data)))
		else $error("stalled word changed before the buffer took it");

	a_block_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(done_reg) |-> (queued_cnt_reg == 9'h100 && state_reg == ST_IDLE))
		else $error("block did not hold exactly 256 words");

	a_done_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(done_reg) |=> (!done_reg))
		else $error("done pulse longer than one cycle");

	// Fixed geometry and capacity words
	a_cyls_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_CYLS) |-> (push_data == 16'h3fff))
		else $error("cylinders word wrong");

	a_lba_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_LBA_LO) |-> (push_data == LBA_CAPACITY[15:0]))
		else $error("LBA capacity low word wrong");

	// Text placement: serial ends its field, firmware starts its own, model ends in text or blank
	a_serial_tail: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_SERIAL_LAST)
			|-> (push_data[7:0] == ((SERIAL[7:0] == 8'h00) ? `BLANK : SERIAL[7:0])))
		else $error("serial number not right-justified");

	a_fwrev_head: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_FWREV_FIRST)
			|-> (push_data[15:8] == ((FWREV[63:56] == 8'h00) ? `BLANK : FWREV[63:56])))
		else $error("firmware revision not left-justified");

	a_model_tail: assert property (@(posedge ref_clk_i) disable iff (!rst_n_reg)
		(push_valid && index_reg == `W_MODEL_LAST)
			|-> (push_data[7:0] == ((MODEL[7:0] == 8'h00) ? `BLANK : MODEL[7:0])))
		else $error("model name tail not text or blank");

endmodule // ata_identify_data_builder

// File: ata_identify_data_builder_tb_top.sv
// Self-checking bench for the identify parameter block generator
`timescale 1ns/1ns
module ata_identify_data_builder_tb_top;
	import ata_id_pkg::*;
	localparam logic [31:0] lba = 32'h0123_4567;
	localparam logic [159:0] ser = "XY42";
	localparam logic [63:0] fw = "2.1a    ";
	localparam logic [319:0] md = "TEST DRIVE                              ";
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_v = 1'b0;
	logic [7:0] code = 8'h00;
	cfg_t cfg_q = '0;
	logic slow_q = 1'b0;
	logic [15:0] word;
	logic valid, ready, busy, done;
	logic [15:0] expq[$];
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;

	// Free-running clock at 125 MHz
	initial
	begin
		forever #4 clk = ~clk;
	end

	ata_identify_data_builder #(.LBA_CAPACITY(lba), .SERIAL(ser), .FWREV(fw), .MODEL(md), .FIFO_DEPTH(8)) dut (
		.ref_clk_i(clk), .reset_n_i(rst_n), .cmd_valid_i(cmd_v), .cmd_code_i(code), .cfg_i(cfg_q),
		.word_o(word), .word_valid_o(valid), .word_ready_i(ready), .busy_o(busy), .done_o(done));

	ata_host_reader host (.clk_i(clk), .rst_n_i(rst_n), .word_valid_i(valid), .word_ready_o(ready), .slow_i(slow_q));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic check_bit(input string name, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("ERROR %s expected %b seen %b", name, e, g);
		end
	endtask

	// Zero bytes of a short text parameter read back as blanks
	function automatic logic [15:0] fix(input logic [15:0] w);
		fix = w;
		if (w[15:8] == 8'h00) fix[15:8] = 8'h20;
		if (w[7:0] == 8'h00) fix[7:0] = 8'h20;
	endfunction

	// Reference word of the block for a given configuration snapshot
	function automatic logic [15:0] exp_word(input int i, input cfg_t c);
		case (i)
			0: exp_word = 16'h0040;
			1: exp_word = 16'h3fff;
			3: exp_word = 16'h0010;
			6: exp_word = 16'h003f;
			20: exp_word = 16'h0003;
			21: exp_word = 16'h0400;
			22: exp_word = 16'h0004;
			47: exp_word = 16'h8010;
			49: exp_word = 16'h0b00;
			50: exp_word = 16'h4000;
			51: exp_word = 16'h0400;
			52: exp_word = 16'h0200;
			53: exp_word = 16'h0007;
			54: exp_word = c.cur_cyl;
			55: exp_word = c.cur_heads;
			56: exp_word = c.cur_spt;
			57: exp_word = c.cur_cap[15:0];
			58: exp_word = c.cur_cap[31:16];
			59: exp_word = {7'h00, c.mult_en, c.mult_count};
			60: exp_word = lba[15:0];
			61: exp_word = lba[31:16];
			63: exp_word = {5'h00, c.dma_sel, 5'h00, 3'h7};
			64: exp_word = 16'h0003;
			65, 66, 68: exp_word = 16'h0078;
			67: exp_word = 16'h00f0;
			80: exp_word = 16'h003e;
			81: exp_word = 16'h0015;
			82: exp_word = 16'h346b;
			83: exp_word = 16'h4008;
			84, 87: exp_word = 16'h4000;
			85: exp_word = c.feat_en & 16'h346b;
			default: exp_word = 16'h0000;
		endcase
		if (i >= 10 && i <= 19) exp_word = fix(ser[159 - 16 * (i - 10) -: 16]);
		if (i >= 23 && i <= 26) exp_word = fix(fw[63 - 16 * (i - 23) -: 16]);
		if (i >= 27 && i <= 46) exp_word = fix(md[319 - 16 * (i - 27) -: 16]);
	endfunction

	// Random live configuration with a legal multiple count and one-hot DMA mode
	function automatic cfg_t rnd_cfg(input int n);
		logic [127:0] r;
		r = {$urandom, $urandom, $urandom, $urandom};
		rnd_cfg = r[107:0];
		rnd_cfg.mult_count = 8'h02 << (n % 4);
		rnd_cfg.dma_sel = 3'h1 << (n % 3);
		rnd_cfg.mult_en = n[0];
	endfunction

	// One identify, with a refused repeat while busy and a config change mid-transfer
	task automatic ident(input cfg_t c, input logic slow);
		int k;
		slow_q <= slow;
		cfg_q <= c;
		@(posedge clk);
		cmd_v <= 1'b1;
		code <= 8'hec;
		for (k = 0; k < 256; k++) expq.push_back(exp_word(k, c));
		@(posedge clk);
		cmd_v <= 1'b0;
		cfg_q <= rnd_cfg(k + 1);
		@(posedge clk);
		#1 check_bit("busy after take", 1'b1, busy);
		@(posedge clk);
		cmd_v <= 1'b1;
		@(posedge clk);
		cmd_v <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			@(posedge clk);
			#1 k++;
		end
		check_bit("done pulse", 1'b1, done);
		check_bit("busy at done", 1'b0, busy);
		@(posedge clk);
		#1 check_bit("done width", 1'b0, done);
		while (expq.size() > 0 && k < 6000)
		begin
			@(posedge clk);
			#1 k++;
		end
		check_bit("block drained", 1'b1, expq.size() == 0);
	endtask

	// Watcher: every word taken by the host is compared with the oldest note
	always @(posedge clk)
	begin
		if (rst_n === 1'b1 && valid === 1'b1 && ready === 1'b1)
		begin
			if (expq.size() == 0)
				check_word("unexpected word", 16'hxxxx, word);
			else
				check_word("identify word", expq.pop_front(), word);
		end
	end

	// Hang guard well above the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			stop_test();
		end
	end

	// Main sequence
	initial
	begin
		static logic [7:0] bad[4] = '{8'h00, 8'hee, 8'hef, 8'h20};
		void'($urandom(66));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		#1 check_bit("valid idle", 1'b0, valid);
		check_bit("busy idle", 1'b0, busy);
		check_bit("done idle", 1'b0, done);
		foreach (bad[i])
		begin
			@(posedge clk);
			cmd_v <= 1'b1;
			code <= bad[i];
			@(posedge clk);
			cmd_v <= 1'b0;
			repeat (3) @(posedge clk);
			#1 check_bit("other opcode", 1'b0, busy | valid);
		end
		for (int n = 0; n < 4; n++) ident(rnd_cfg(n), n[0]);
		stop_test();
	end
endmodule // ata_identify_data_builder_tb_top
